//--- froes_pkg.sv
// Purpose: constants for the read-option and error-status register block
// Assumes: single-lane opcode/data framing on the host link
// Notes: dummy counts are the power-up defaults of the fast-read family
// Behaviour
// - single-lane fast read 0Bh/0Dh uses 8 dummies in SPI; unique-ID, info-row too
// - fast read 0Bh/0Dh uses 6 dummies in four-lane command mode
// - dual-output read 3Bh uses 8 dummies, no DDR variant
// - dual I/O read BBh/BDh uses 4 dummies in SPI mode
// - quad-output read 6Bh uses 8 dummies, no DDR variant
// - quad I/O read EBh/EDh uses 6 dummies in SPI and four-lane mode
// - dual I/O DDR read is accepted only in SPI mode
// - bits 7:5 drive strength, 4 reserved, 3..0 erase/program/protect/busy; reset f0
// - read-only bits 3:0 unchanged by either set-read-option command
// - 85h writes non-volatile copy, 83h volatile; both select drive strength
// - drive codes 001,011,101,110,111 defined; 000,100 reserved, 010 unspecified
// - bit 0 mirrors the busy flag: 0 ready, 1 busy
// - page/quad program or function write failure sets program error; protected sets both
// - info-row program failure sets program error; locked region sets both
// - non-volatile update erase failure sets erase error, program failure program error
// - locked status write sets protection and erase error; no other write does
// - erases set erase error on failure, plus protection on protected; chip erase too
// - one-time bits only go to 1; zero writes ignored without error
// - data bits aimed at read-only bits are discarded without error
// - error flags stay set until clear command, hardware or software reset
// - error flags never block or reject later commands
package froes_pkg;
  // register layout
  localparam int FROES_DS_MSB = 7;
  localparam int FROES_DS_LSB = 5;
  localparam int FROES_RSVD_BIT = 4;
  localparam int FROES_EERR_BIT = 3;
  localparam int FROES_PERR_BIT = 2;
  localparam int FROES_PROT_BIT = 1;
  localparam int FROES_WIP_BIT = 0;
  localparam logic [7:0] FROES_REG_RESET = 8'hf0;
  localparam logic [2:0] FROES_DS_RESET = 3'h7;
  // command opcodes
  localparam logic [7:0] FROES_OP_SET_NV = 8'h85;
  localparam logic [7:0] FROES_OP_SET_VOL = 8'h83;
  localparam logic [7:0] FROES_OP_CLEAR = 8'h82;
  localparam logic [7:0] FROES_OP_READ_REG = 8'h81;
  localparam logic [7:0] FROES_OP_SOFT_RESET = 8'h99;
  localparam logic [7:0] FROES_OP_FAST = 8'h0b;
  localparam logic [7:0] FROES_OP_FAST_DDR = 8'h0d;
  localparam logic [7:0] FROES_OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] FROES_OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] FROES_OP_DUAL_IO_DDR = 8'hbd;
  localparam logic [7:0] FROES_OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] FROES_OP_QUAD_IO = 8'heb;
  localparam logic [7:0] FROES_OP_QUAD_IO_DDR = 8'hed;
  localparam logic [7:0] FROES_OP_UID_READ = 8'h4b;
  localparam logic [7:0] FROES_OP_INFO_READ = 8'h68;
  // default dummy counts
  localparam logic [3:0] FROES_DUM_FAST_SPI = 4'h8;
  localparam logic [3:0] FROES_DUM_FAST_QPI = 4'h6;
  localparam logic [3:0] FROES_DUM_DUAL_OUT = 4'h8;
  localparam logic [3:0] FROES_DUM_DUAL_IO = 4'h4;
  localparam logic [3:0] FROES_DUM_QUAD_OUT = 4'h8;
  localparam logic [3:0] FROES_DUM_QUAD_IO = 4'h6;

  typedef enum logic [1:0] {FROES_RD_NONE, FROES_RD_OK, FROES_RD_REJECT} froes_rd_t;

  // read-opcode class and its default dummy count
  function automatic logic [5:0] froes_dummy(input logic [7:0] op, input logic qpi);
    froes_rd_t k;
    logic [3:0] d;
    k = FROES_RD_OK;
    d = 4'h0;
    case (op)
      FROES_OP_FAST, FROES_OP_FAST_DDR: d = qpi ? FROES_DUM_FAST_QPI : FROES_DUM_FAST_SPI;
      FROES_OP_UID_READ, FROES_OP_INFO_READ: d = FROES_DUM_FAST_SPI;
      FROES_OP_DUAL_OUT: if (qpi) k = FROES_RD_REJECT; else d = FROES_DUM_DUAL_OUT;
      FROES_OP_DUAL_IO: if (qpi) k = FROES_RD_REJECT; else d = FROES_DUM_DUAL_IO;
      FROES_OP_DUAL_IO_DDR: if (qpi) k = FROES_RD_REJECT; else d = FROES_DUM_DUAL_IO;
      FROES_OP_QUAD_OUT: if (qpi) k = FROES_RD_REJECT; else d = FROES_DUM_QUAD_OUT;
      FROES_OP_QUAD_IO, FROES_OP_QUAD_IO_DDR: d = FROES_DUM_QUAD_IO;
      default: k = FROES_RD_NONE;
    endcase
    return {k, d};
  endfunction : froes_dummy
endpackage : froes_pkg

//--- froes_link.sv
// Purpose: link-clock side: shifts in opcode and data byte, shifts out register
// Assumes: single-lane framing, data sampled on rising and driven on falling edge
// Notes: chip select high ends the frame and clears the bit counter
`timescale 1ns/1ns
module froes_link
  import froes_pkg::*;
(
  input wire logic sck_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic [7:0] reg_i,
  output logic so_o,
  output logic so_oe_o,
  output logic op_tgl_o,
  output logic [7:0] op_o,
  output logic wr_tgl_o,
  output logic [7:0] wr_op_o,
  output logic [7:0] wr_data_o
);
  logic frame_rst_n;
  logic [4:0] bit_cnt;
  logic [6:0] sh;
  logic [7:0] rd_meta;
  logic [7:0] rd_sync;
  logic is_set;

  // the frame's own select ends everything that belongs to the frame
  assign frame_rst_n = resetn_i & ~cs_n_i;
  assign is_set = (op_o == FROES_OP_SET_NV) || (op_o == FROES_OP_SET_VOL);

  // bit counter and shifter, cleared per frame
  always_ff @(posedge sck_i or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt <= 5'h00;
      sh <= 7'h00;
    end
    else
    begin
      sh <= {sh[5:0], si_i};
      if (bit_cnt != 5'h10)
        bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // held words and toggles survive the frame so no event is lost
  always_ff @(posedge sck_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      op_o <= 8'h00;
      op_tgl_o <= 1'b0;
      wr_tgl_o <= 1'b0;
      wr_op_o <= 8'h00;
      wr_data_o <= 8'h00;
    end
    else if (!cs_n_i)
    begin
      if (bit_cnt == 5'h07)
      begin
        op_o <= {sh, si_i};
        op_tgl_o <= ~op_tgl_o;
      end
      if (bit_cnt == 5'h0f && is_set)
      begin
        wr_op_o <= op_o;
        wr_data_o <= {sh, si_i};
        wr_tgl_o <= ~wr_tgl_o;
      end
    end
  end

  // register image: each bit is an independent level, two flops per bit
  always_ff @(posedge sck_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rd_meta <= FROES_REG_RESET;
      rd_sync <= FROES_REG_RESET;
    end
    else
    begin
      rd_meta <= reg_i;
      rd_sync <= rd_meta;
    end
  end

  // readout msb first; once the byte is out the counter holds and bit 7 repeats
  always_ff @(negedge sck_i or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      so_o <= 1'b0;
    else
      so_o <= rd_sync[3'h7 - bit_cnt[2:0]];
  end

  assign so_oe_o = !cs_n_i && (op_o == FROES_OP_READ_REG) && bit_cnt[4:3] != 2'b00;
endmodule : froes_link

//--- froes_top.sv
// Purpose: read-option and error-status register with fast-read dummy lookup
// Assumes: engine event inputs are one-cycle pulses on CLK_I
// Notes: the link logic runs on LINK_SCK_I, commands cross by toggles
`timescale 1ns/1ns
module froes_top
  import froes_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic LINK_SCK_I,
  input wire logic LINK_CS_N_I,
  input wire logic LINK_SI_I,
  output logic LINK_SO_O,
  output logic LINK_SO_OE_O,
  input wire logic QPI_MODE_I,
  input wire logic BUSY_I,
  input wire logic [2:0] NV_DS_I,
  input wire logic PGM_FAIL_I,
  input wire logic PGM_PROT_I,
  input wire logic ERS_FAIL_I,
  input wire logic ERS_PROT_I,
  input wire logic CHIP_ERASE_I,
  input wire logic BP_NONZERO_I,
  input wire logic SR_WRITE_I,
  input wire logic STATUS_WRITE_LOCK_I,
  input wire logic WP_N_I,
  input wire logic NV_ERS_FAIL_I,
  input wire logic NV_PGM_FAIL_I,
  output logic [2:0] DRIVE_STRENGTH_O,
  output logic [2:0] NV_DRIVE_STRENGTH_O,
  output logic NV_WRITE_REQ_O,
  output logic READ_CMD_O,
  output logic READ_REJECT_O,
  output logic [3:0] DUMMY_CYCLES_O,
  output logic [7:0] READ_OPCODE_O,
  output logic [7:0] READ_OPTION_REG_O
);
  logic op_tgl;
  logic [7:0] op_word;
  logic wr_tgl;
  logic [7:0] wr_op;
  logic [7:0] wr_data;
  logic [2:0] op_sync;
  logic [2:0] wr_sync;
  logic [1:0] wp_sync;
  logic op_evt;
  logic wr_evt;
  logic nv_loaded;
  logic [2:0] ds_vol;
  logic [2:0] ds_nv;
  logic protect_violation_flag;
  logic p_err;
  logic e_err;
  logic write_in_progress;
  logic clr_evt;
  logic sr_lock_hit;
  logic chip_bp_hit;
  logic next_prot;
  logic next_p;
  logic next_e;
  logic [5:0] rd_class;
  logic set_vol_evt;
  logic set_nv_evt;

  // link side on its own clock; the register image goes out as levels
  froes_link u_link (
    .sck_i(LINK_SCK_I),
    .resetn_i(RESETN_I),
    .cs_n_i(LINK_CS_N_I),
    .si_i(LINK_SI_I),
    .reg_i(READ_OPTION_REG_O),
    .so_o(LINK_SO_O),
    .so_oe_o(LINK_SO_OE_O),
    .op_tgl_o(op_tgl),
    .op_o(op_word),
    .wr_tgl_o(wr_tgl),
    .wr_op_o(wr_op),
    .wr_data_o(wr_data)
  );

  // toggle synchronisers; the held words are stable long before the edge
  // arrives, since a link bit lasts many core cycles
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      op_sync <= 3'h0;
      wr_sync <= 3'h0;
      wp_sync <= 2'h3;
    end
    else
    begin
      op_sync <= {op_sync[1:0], op_tgl};
      wr_sync <= {wr_sync[1:0], wr_tgl};
      wp_sync <= {wp_sync[0], WP_N_I};
    end
  end

  // edges are taken between the second and third flops only
  assign op_evt = op_sync[2] ^ op_sync[1];
  assign wr_evt = wr_sync[2] ^ wr_sync[1];
  assign set_vol_evt = wr_evt && (wr_op == FROES_OP_SET_VOL);
  assign set_nv_evt = wr_evt && (wr_op == FROES_OP_SET_NV);

  // clear by command or by software reset; hardware reset is RESETN_I
  assign clr_evt = op_evt && (op_word == FROES_OP_CLEAR || op_word == FROES_OP_SOFT_RESET);

  // locked status write: write-lock bit plus write-protect pin low
  assign sr_lock_hit = SR_WRITE_I && STATUS_WRITE_LOCK_I && !wp_sync[1];
  // chip erase with any block-protect bit set is refused as protected
  assign chip_bp_hit = CHIP_ERASE_I && BP_NONZERO_I;

  // next flag values: a set in the clearing cycle wins over the clear
  always_comb
  begin
    next_prot = PGM_PROT_I || ERS_PROT_I || sr_lock_hit || chip_bp_hit;
    next_p = PGM_FAIL_I || PGM_PROT_I || NV_PGM_FAIL_I;
    next_e = ERS_FAIL_I || ERS_PROT_I || NV_ERS_FAIL_I || sr_lock_hit || chip_bp_hit;
    next_prot = next_prot || (protect_violation_flag && !clr_evt);
    next_p = next_p || (p_err && !clr_evt);
    next_e = next_e || (e_err && !clr_evt);
  end

  // sticky error flags; set-read-option writes never reach them
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      protect_violation_flag <= FROES_REG_RESET[FROES_PROT_BIT];
      p_err <= FROES_REG_RESET[FROES_PERR_BIT];
      e_err <= FROES_REG_RESET[FROES_EERR_BIT];
    end
    else
    begin
      protect_violation_flag <= next_prot;
      p_err <= next_p;
      e_err <= next_e;
    end
  end

  // busy mirror, one cycle behind the status register flag
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      write_in_progress <= FROES_REG_RESET[FROES_WIP_BIT];
    else
      write_in_progress <= BUSY_I;
  end

  // drive strength: the stored copy is caught once after reset release,
  // because an async reset may only load constants
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      nv_loaded <= 1'b0;
      ds_vol <= FROES_DS_RESET;
      ds_nv <= FROES_DS_RESET;
    end
    else if (!nv_loaded)
    begin
      nv_loaded <= 1'b1;
      ds_nv <= NV_DS_I;
      ds_vol <= NV_DS_I;
    end
    else if (set_nv_evt)
    begin
      ds_nv <= wr_data[FROES_DS_MSB:FROES_DS_LSB];
      ds_vol <= wr_data[FROES_DS_MSB:FROES_DS_LSB];
    end
    else if (set_vol_evt)
      ds_vol <= wr_data[FROES_DS_MSB:FROES_DS_LSB];
  end

  // codes are stored as written; reserved codes are the host's concern
  assign DRIVE_STRENGTH_O = ds_vol;
  assign NV_DRIVE_STRENGTH_O = ds_nv;

  // request to the engine to erase and reprogram the stored copy
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      NV_WRITE_REQ_O <= 1'b0;
    else
      NV_WRITE_REQ_O <= set_nv_evt && nv_loaded;
  end

  // register image; the reserved bit reads as its default one
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      READ_OPTION_REG_O <= FROES_REG_RESET;
    else
    begin
      READ_OPTION_REG_O[FROES_DS_MSB:FROES_DS_LSB] <= ds_vol;
      READ_OPTION_REG_O[FROES_RSVD_BIT] <= FROES_REG_RESET[FROES_RSVD_BIT];
      READ_OPTION_REG_O[FROES_EERR_BIT] <= e_err;
      READ_OPTION_REG_O[FROES_PERR_BIT] <= p_err;
      READ_OPTION_REG_O[FROES_PROT_BIT] <= protect_violation_flag;
      READ_OPTION_REG_O[FROES_WIP_BIT] <= write_in_progress;
    end
  end

  // read classification; note it never looks at the error flags
  assign rd_class = froes_dummy(op_word, QPI_MODE_I);

  // read-command hand-off to the data path with its dummy count
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      READ_CMD_O <= 1'b0;
      READ_REJECT_O <= 1'b0;
      DUMMY_CYCLES_O <= 4'h0;
      READ_OPCODE_O <= 8'h00;
    end
    else
    begin
      READ_CMD_O <= op_evt && (rd_class[5:4] == FROES_RD_OK);
      READ_REJECT_O <= op_evt && (rd_class[5:4] == FROES_RD_REJECT);
      if (op_evt && rd_class[5:4] == FROES_RD_OK)
      begin
        DUMMY_CYCLES_O <= rd_class[3:0];
        READ_OPCODE_O <= op_word;
      end
    end
  end

  // the host's dummy count and mode-bit tri-state are its own duty

  // one-time bits of the function register live elsewhere; nothing here
  // raises an error for a write of zero to them

  // checks
  sequence set_vol_s;
    set_vol_evt && nv_loaded;
  endsequence

  // the register image trails the held copy by one core edge; it is checked two edges on
  sequence image_s;
    1'b1 ##2 1'b1;
  endsequence

  // no engine event in this cycle, so the flags have no reason to rise
  sequence quiet_s;
    !(PGM_FAIL_I || PGM_PROT_I || ERS_FAIL_I || ERS_PROT_I
      || CHIP_ERASE_I || SR_WRITE_I || NV_ERS_FAIL_I || NV_PGM_FAIL_I);
  endsequence

  ds_vol_write_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    set_vol_s |-> ##1 (ds_vol == $past(wr_data[7:5])) ##0 image_s
      ##0 (READ_OPTION_REG_O[7:5] == $past(wr_data[7:5], 3)))
    else $error("volatile drive strength not taken from 83h data");

  nv_write_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (set_nv_evt && nv_loaded) |=> NV_WRITE_REQ_O && ds_nv == $past(wr_data[7:5]))
    else $error("85h did not update stored copy");

  ro_bits_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (wr_evt && !op_evt) ##0 quiet_s |=> $stable({e_err, p_err, protect_violation_flag}))
    else $error("set-read-option write touched error bits");

  flag_hold_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    $fell(e_err) || $fell(p_err) || $fell(protect_violation_flag) |-> $past(clr_evt))
    else $error("error flag dropped without a clear");

  prog_prot_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    PGM_PROT_I |=> (p_err && protect_violation_flag) ##1 (READ_OPTION_REG_O[2:1] == 2'b11))
    else $error("protected program did not set both flags");

  sr_lock_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    SR_WRITE_I && STATUS_WRITE_LOCK_I && !wp_sync[1] |=> protect_violation_flag && e_err)
    else $error("locked status write did not flag");

  chip_bp_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    CHIP_ERASE_I && BP_NONZERO_I |=> protect_violation_flag && e_err)
    else $error("chip erase with block protect did not flag");

  nv_fail_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    NV_ERS_FAIL_I && !NV_PGM_FAIL_I |=> e_err)
    else $error("stored-copy erase failure not flagged");

  wip_mirror_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    ##2 READ_OPTION_REG_O[0] == $past(BUSY_I, 2))
    else $error("busy mirror lags wrong");

  qpi_dummy_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    op_evt && op_word == FROES_OP_FAST && QPI_MODE_I |=> READ_CMD_O && DUMMY_CYCLES_O == 4'h6)
    else $error("four-lane fast read dummy count wrong");

  ddr_reject_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    op_evt && op_word == FROES_OP_DUAL_IO_DDR && QPI_MODE_I |=> READ_REJECT_O && !READ_CMD_O)
    else $error("dual DDR read taken in four-lane mode");

  no_block_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    op_evt && op_word == FROES_OP_QUAD_IO && (p_err || e_err || protect_violation_flag)
      |=> READ_CMD_O && DUMMY_CYCLES_O == 4'h6)
    else $error("error flags blocked a read");

  // start-up load, single-source flags, clears and the single-lane fast and dual DDR reads
  boot_load_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    !nv_loaded |=> nv_loaded && ds_vol == $past(NV_DS_I) && ds_nv == $past(NV_DS_I))
    else $error("stored drive code not loaded after reset");

  pgm_fail_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    PGM_FAIL_I |=> p_err)
    else $error("program failure not flagged");

  ers_prot_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    ERS_PROT_I |=> e_err && protect_violation_flag)
    else $error("protected erase did not set both flags");

  flag_clear_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    clr_evt ##0 quiet_s |=> (!e_err && !p_err && !protect_violation_flag)
      ##1 (READ_OPTION_REG_O[3:1] == 3'h0))
    else $error("clear command left an error flag set");

  spi_dummy_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    op_evt && op_word == FROES_OP_FAST && !QPI_MODE_I
      |=> READ_CMD_O && DUMMY_CYCLES_O == FROES_DUM_FAST_SPI)
    else $error("single-lane fast read dummy count wrong");

  ddr_spi_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    op_evt && op_word == FROES_OP_DUAL_IO_DDR && !QPI_MODE_I
      |=> READ_CMD_O && !READ_REJECT_O && DUMMY_CYCLES_O == FROES_DUM_DUAL_IO)
    else $error("dual DDR read refused in single-lane mode");

  nv_req_only_a: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    NV_WRITE_REQ_O |-> $past(set_nv_evt))
    else $error("stored-copy request without 85h");
endmodule : froes_top

//--- froes_host_model.sv
// Purpose: host-side serial controller model for the flash link
// Assumes: single lane, clock idles low and stands still between frames
// Notes: si shows the inverse of its last bit outside frames
`timescale 1ns/1ns
module froes_host_model
(
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  // idle lines from time zero
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b1;
  end

  // one frame: opcode, then data byte or read-back bits
  task automatic xfer(input logic [7:0] op, input logic [7:0] data, input int nbits,
                      output logic [7:0] rd, output logic oe_ok);
    logic [15:0] sh;
    sh = {op, data};
    rd = 8'h00;
    oe_ok = 1'b1;
    #7 cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      si_o = sh[15 - i]; // msb first, changed while the clock is low
      #40 sck_o = 1'b1;
      if (i >= 8)
      begin
        rd = {rd[6:0], so_i}; // only listens, so no turnaround clash
        oe_ok = oe_ok & so_oe_i;
      end
      #40 sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    si_o = ~si_o; // a released line must not keep its last value
  endtask : xfer
endmodule : froes_host_model

//--- froes_top_tb.sv
// Purpose: self-checking bench for the read-option and error-status block
// Assumes: event pulses are one core cycle; link frames are made by the host model
// Notes: waits after frames cover the 2-3 cycle crossing plus the register stage
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("FAIL %s expected %h seen %h", nm, exp, got); \
    end \
  end
module froes_top_tb import froes_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic qpi = 1'b0;
  logic busy = 1'b0;
  logic [2:0] nv_ds = 3'h5;
  logic [7:0] ev = 8'h00;
  logic bp = 1'b1;
  logic lock = 1'b1;
  logic wp_n = 1'b0;
  logic sck, cs_n, si, so, so_oe, nvw, rcmd, rrej;
  logic [2:0] ds, nvds;
  logic [3:0] dum;
  logic [7:0] rop, regv, rd;
  logic oe_ok;
  int miscompares = 0;
  int check_count = 0;
  int cmd_cnt = 0;
  int rej_cnt = 0;
  int nvw_cnt = 0;

  always #2 clk = ~clk;

  froes_host_model i_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));

  froes_top i_dut (.CLK_I(clk), .RESETN_I(rst_n), .LINK_SCK_I(sck), .LINK_CS_N_I(cs_n),
    .LINK_SI_I(si), .LINK_SO_O(so), .LINK_SO_OE_O(so_oe), .QPI_MODE_I(qpi), .BUSY_I(busy),
    .NV_DS_I(nv_ds), .PGM_FAIL_I(ev[0]), .PGM_PROT_I(ev[1]), .ERS_FAIL_I(ev[2]),
    .ERS_PROT_I(ev[3]), .CHIP_ERASE_I(ev[4]), .BP_NONZERO_I(bp), .SR_WRITE_I(ev[5]),
    .STATUS_WRITE_LOCK_I(lock), .WP_N_I(wp_n), .NV_ERS_FAIL_I(ev[6]), .NV_PGM_FAIL_I(ev[7]),
    .DRIVE_STRENGTH_O(ds), .NV_DRIVE_STRENGTH_O(nvds), .NV_WRITE_REQ_O(nvw),
    .READ_CMD_O(rcmd), .READ_REJECT_O(rrej), .DUMMY_CYCLES_O(dum), .READ_OPCODE_O(rop),
    .READ_OPTION_REG_O(regv));

  // one-cycle pulses are counted so a frame task never misses them
  always @(posedge clk)
  begin
    if (rcmd === 1'b1) cmd_cnt++;
    if (rrej === 1'b1) rej_cnt++;
    if (nvw === 1'b1) nvw_cnt++;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // link frame then enough core cycles for the crossing to land
  task automatic frame(input logic [7:0] op, input logic [7:0] data, input int nbits);
    i_host.xfer(op, data, nbits, rd, oe_ok);
    wait_clk(8);
  endtask : frame

  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 8'h00;
    wait_clk(3);
  endtask : pulse

  // reset image, then stored drive code loaded at start-up
  task automatic t_reset;
    wait_clk(4);
    `CHK("reset reg", 8'hf0, regv)
    `CHK("reset dummy", 4'h0, dum)
    @(posedge clk);
    rst_n <= 1'b1;
    wait_clk(3);
    `CHK("boot drive", nv_ds, ds)
    `CHK("boot reg", {nv_ds, 5'h10}, regv)
  endtask : t_reset

  // busy bit follows the status busy flag, also when read over the link
  task automatic t_busy;
    @(posedge clk);
    busy <= 1'b1;
    wait_clk(3);
    `CHK("busy bit", 1'b1, regv[FROES_WIP_BIT])
    frame(FROES_OP_READ_REG, 8'h00, 16);
    `CHK("link read", {nv_ds, 5'h11}, rd)
    `CHK("so enable", 1'b1, oe_ok)
    `CHK("so released", 1'b0, so_oe)
    busy <= 1'b0;
    wait_clk(3);
    `CHK("ready bit", 1'b0, regv[FROES_WIP_BIT])
  endtask : t_busy

  // every drive code through the volatile set, low data bits all ones
  task automatic t_drive;
    int n;
    for (int c = 0; c < 8; c++)
    begin
      frame(FROES_OP_SET_VOL, {3'(c), 5'h1f}, 16);
      `CHK("vol drive", 3'(c), ds)
      `CHK("vol reg", {3'(c), 5'h10}, regv)
      `CHK("nv untouched", nv_ds, nvds)
    end
    n = nvw_cnt;
    frame(FROES_OP_SET_NV, 8'h6a, 16);
    `CHK("nv drive", 3'h3, nvds)
    `CHK("nv to vol", 3'h3, ds)
    `CHK("nv request", 1, nvw_cnt - n)
  endtask : t_drive

  // each failure source, its sticky flags, a set command meanwhile, then clear
  task automatic t_flags;
    logic [2:0] exp [8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h5, 3'h4, 3'h2};
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i);
      `CHK("flag set", exp[i], regv[3:1])
      wait_clk(20);
      `CHK("flag held", exp[i], regv[3:1])
      frame(FROES_OP_SET_VOL, 8'hdf, 16);
      `CHK("cmd while err", 3'h6, ds)
      `CHK("flags kept", {3'h6, 1'b1, exp[i], 1'b0}, regv)
      frame(i[0] ? FROES_OP_SOFT_RESET : FROES_OP_CLEAR, 8'h00, 8);
      `CHK("flag clear", 3'h0, regv[3:1])
    end
    // back to back program and erase failures
    @(posedge clk);
    ev <= 8'h01;
    @(posedge clk);
    ev <= 8'h04;
    pulse(8'h00);
    `CHK("both flags", 3'h6, regv[3:1])
    frame(FROES_OP_CLEAR, 8'h00, 8);
    bp <= 1'b0;
    pulse(8'h10);
    `CHK("chip unprot", 3'h0, regv[3:1])
    wp_n <= 1'b1;
    wait_clk(4);
    pulse(8'h20);
    `CHK("sr unlocked", 3'h0, regv[3:1])
  endtask : t_flags

  // default dummy counts: {op, 2'b0, qpi, reject, count}
  task automatic t_dummy;
    logic [15:0] tab [16] = '{16'h0b08, 16'h0d08, 16'h0b26, 16'h0d26, 16'h4b08, 16'h6808,
      16'h3b08, 16'h3b30, 16'hbb04, 16'hbd04, 16'hbd30, 16'h6b08, 16'heb06, 16'heb26,
      16'hed06, 16'hed26};
    int c0;
    int r0;
    logic [3:0] pd;
    logic [7:0] po;
    pulse(8'h02); // reads below run with error flags set, which must not stop them
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      qpi <= tab[i][5];
      wait_clk(2);
      c0 = cmd_cnt;
      r0 = rej_cnt;
      pd = dum;
      po = rop;
      frame(tab[i][15:8], 8'h00, 8);
      `CHK("accepted", int'(!tab[i][4]), cmd_cnt - c0)
      `CHK("rejected", int'(tab[i][4]), rej_cnt - r0)
      `CHK("dummy", tab[i][4] ? pd : tab[i][3:0], dum)
      `CHK("opcode", tab[i][4] ? po : tab[i][15:8], rop)
    end
    `CHK("err kept", 3'h3, regv[3:1])
    qpi <= 1'b0;
    frame(FROES_OP_CLEAR, 8'h00, 8);
    `CHK("err cleared", 3'h0, regv[3:1])
  endtask : t_dummy

  // hardware reset clears a set flag and reloads the stored drive code
  task automatic t_hwreset;
    pulse(8'h04);
    `CHK("pre reset", 3'h4, regv[3:1])
    rst_n <= 1'b0;
    wait_clk(4);
    `CHK("in reset", 8'hf0, regv)
    rst_n <= 1'b1;
    wait_clk(3);
    `CHK("after reset", {nv_ds, 5'h10}, regv)
  endtask : t_hwreset

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // tests take about 42 us of link traffic; allow over seven times that
  initial
  begin
    #300000;
    miscompares++;
    stop_test();
  end

  initial
  begin
    t_reset();
    t_busy();
    t_drive();
    t_flags();
    t_dummy();
    t_hwreset();
    stop_test();
  end
endmodule : froes_top_tb
